//--- modem_status_pkg.sv
package modem_status_pkg;
    // Field positions inside the modem status register
    localparam int CTS_CHANGED_BIT = 0;
    localparam int DCD_CHANGED_BIT = 3;
    localparam int CTS_LEVEL_BIT = 4;
    localparam int DCD_LEVEL_BIT = 7;
    // Number of serial channels
    localparam int CHANNEL_COUNT = 2;
    // Status register width and reset value
    localparam int STATUS_WIDTH = 8;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Inputs rest high (inactive) at reset
    localparam logic [2:0] SYNC_RESET = 3'h7;
endpackage

//--- modem_status_inputs.sv
module modem_status_inputs #(
    parameter int CHANNELS = modem_status_pkg::CHANNEL_COUNT
) (
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Modem pins, active low, one bit per channel
    input wire logic [CHANNELS-1:0] CTS_N,
    input wire logic [CHANNELS-1:0] DCD_N,
    // Host side, one read strobe and one enable per channel
    input wire logic [CHANNELS-1:0] STATUS_READ,
    input wire logic [CHANNELS-1:0] MODEM_IRQ_ENABLE,
    // Status register and interrupt requests
    output logic [CHANNELS*8-1:0] MODEM_STATUS_REGISTER,
    output logic [CHANNELS-1:0] MODEM_IRQ
);

    // Change of a filtered level: second and third stages agree and differ from held.
    // A pulse that never lasts long enough for both stages to agree is ignored.
    function automatic logic settled_change(input logic [2:0] sync, input logic held);
        settled_change = (sync[1] == sync[2]) && (sync[2] != held);
    endfunction

    // Level the channel will hold after this edge: new settled level on an event
    function automatic logic follow_level(
        input logic event_seen,
        input logic settled,
        input logic held
    );
        if (event_seen)
            follow_level = settled;
        else
            follow_level = held;
    endfunction

    // Place inverted levels and change flags at their register positions.
    // Every bit not owned by this block reads as zero.
    function automatic logic [modem_status_pkg::STATUS_WIDTH-1:0] pack_status(
        input logic cts_active,
        input logic dcd_active,
        input logic cts_flag,
        input logic dcd_flag
    );
        logic [modem_status_pkg::STATUS_WIDTH-1:0] image;
        image = modem_status_pkg::STATUS_RESET;
        image[modem_status_pkg::CTS_CHANGED_BIT] = cts_flag;
        image[modem_status_pkg::DCD_CHANGED_BIT] = dcd_flag;
        image[modem_status_pkg::CTS_LEVEL_BIT] = cts_active;
        image[modem_status_pkg::DCD_LEVEL_BIT] = dcd_active;
        pack_status = image;
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : chan
            // Per-channel state, no sharing between channels
            logic [2:0] cts_sync;
            logic [2:0] dcd_sync;
            logic cts_level;
            logic dcd_level;
            logic cts_changed;
            logic dcd_changed;
            logic [modem_status_pkg::STATUS_WIDTH-1:0] status;
            logic irq;
            wire cts_event;
            wire dcd_event;
            wire next_cts_changed;
            wire next_dcd_changed;
            wire [modem_status_pkg::STATUS_WIDTH-1:0] next_status;
            wire next_irq;
            wire next_cts_level;
            wire next_dcd_level;

            // Detect settled transitions of each pin
            assign cts_event = settled_change(cts_sync, cts_level);
            assign dcd_event = settled_change(dcd_sync, dcd_level);
            // A read clears the flags unless a new change lands in the same cycle
            assign next_cts_changed = cts_event | (cts_changed & ~STATUS_READ[ch]);
            assign next_dcd_changed = dcd_event | (dcd_changed & ~STATUS_READ[ch]);
            // Levels after this edge, so the image never lags the held level
            assign next_cts_level = follow_level(cts_event, cts_sync[2], cts_level);
            assign next_dcd_level = follow_level(dcd_event, dcd_sync[2], dcd_level);
            // Assemble status image; a low pin reads as a one
            assign next_status = pack_status(~next_cts_level,
                                             ~next_dcd_level,
                                             next_cts_changed,
                                             next_dcd_changed);
            // Interrupt follows the flags gated by enable
            assign next_irq = MODEM_IRQ_ENABLE[ch] & (next_cts_changed | next_dcd_changed);

            // Clear-to-send synchroniser; the first stage feeds only the second
            always_ff @(posedge CLK)
            begin
                if (RST)
                    cts_sync <= modem_status_pkg::SYNC_RESET;
                else if (CE)
                    cts_sync <= {cts_sync[1:0], CTS_N[ch]};
            end

            // Carrier-detect synchroniser; the first stage feeds only the second
            always_ff @(posedge CLK)
            begin
                if (RST)
                    dcd_sync <= modem_status_pkg::SYNC_RESET;
                else if (CE)
                    dcd_sync <= {dcd_sync[1:0], DCD_N[ch]};
            end

            // Held clear-to-send level, starts inactive like the pin's rest level
            always_ff @(posedge CLK)
            begin
                if (RST)
                    cts_level <= modem_status_pkg::SYNC_RESET[2];
                else if (CE)
                    cts_level <= next_cts_level;
            end

            // Held carrier-detect level, starts inactive like the pin's rest level
            always_ff @(posedge CLK)
            begin
                if (RST)
                    dcd_level <= modem_status_pkg::SYNC_RESET[2];
                else if (CE)
                    dcd_level <= next_dcd_level;
            end

            // Clear-to-send change flag; a change in the read cycle survives
            always_ff @(posedge CLK)
            begin
                if (RST)
                    cts_changed <= 1'b0;
                else if (CE)
                    cts_changed <= next_cts_changed;
            end

            // Carrier-detect change flag; a change in the read cycle survives
            always_ff @(posedge CLK)
            begin
                if (RST)
                    dcd_changed <= 1'b0;
                else if (CE)
                    dcd_changed <= next_dcd_changed;
            end

            // Registered status image so the port comes straight from flops
            always_ff @(posedge CLK)
            begin
                if (RST)
                    status <= modem_status_pkg::STATUS_RESET;
                else if (CE)
                    status <= next_status;
            end

            // Registered interrupt; drops with the flags or with the enable
            always_ff @(posedge CLK)
            begin
                if (RST)
                    irq <= 1'b0;
                else if (CE)
                    irq <= next_irq;
            end

            // No path from these pins reaches any transmitter logic
            assign MODEM_STATUS_REGISTER[ch*8 +: 8] = status;
            assign MODEM_IRQ[ch] = irq;
        end
    endgenerate

endmodule

//--- modem_status_monitor.sv
module modem_status_monitor #(parameter int CHANNELS = 2) (
    input wire logic CLK, RST, CE,
    input wire logic [CHANNELS-1:0] CTS_N, DCD_N, STATUS_READ, MODEM_IRQ_ENABLE, MODEM_IRQ,
    input wire logic [CHANNELS*8-1:0] MODEM_STATUS_REGISTER
);
    wire logic [15:0] st = 16'(MODEM_STATUS_REGISTER);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST || !CE);
    property p_cts_lvl; !CTS_N[0][*6] |-> st[4]; endproperty
    a_cts_lvl: assert property (p_cts_lvl) else $error("cts level");
    property p_dcd_lvl; !DCD_N[1][*6] |-> st[15]; endproperty
    a_dcd_lvl: assert property (p_dcd_lvl) else $error("dcd level");
    property p_cts_chg; $fell(CTS_N[0]) |-> ##[3:5] st[0]; endproperty
    a_cts_chg: assert property (p_cts_chg) else $error("cts flag");
    property p_dcd_chg; $rose(DCD_N[1]) |-> ##[3:5] st[11]; endproperty
    a_dcd_chg: assert property (p_dcd_chg) else $error("dcd flag");
    property p_irq0; st[0] && MODEM_IRQ_ENABLE[0] |-> ##[0:1] MODEM_IRQ[0]; endproperty
    a_irq0: assert property (p_irq0) else $error("irq ch0");
    property p_irq1; st[11] && MODEM_IRQ_ENABLE[1] |-> ##[0:1] MODEM_IRQ[1]; endproperty
    a_irq1: assert property (p_irq1) else $error("irq ch1");
    property p_clr; $stable(CTS_N[0])[*5] ##0 STATUS_READ[0] |-> ##2 !st[0]; endproperty
    a_clr: assert property (p_clr) else $error("read clear");
    property p_own; st[8] && !STATUS_READ[1] && !$past(STATUS_READ[1]) |=> st[8]; endproperty
    a_own: assert property (p_own) else $error("channel mix");
    // Main scenarios reached
    c_irq0: cover property (MODEM_IRQ[0]);
    c_irq1: cover property (MODEM_IRQ[1]);
    c_clr: cover property (STATUS_READ[0] ##2 !st[0]);
endmodule
bind modem_status_inputs modem_status_monitor #(.CHANNELS(CHANNELS)) u_modem_status_monitor (
    .CLK, .RST, .CE, .CTS_N, .DCD_N, .STATUS_READ, .MODEM_IRQ_ENABLE, .MODEM_IRQ,
    .MODEM_STATUS_REGISTER);

//--- modem_line_model.sv
module modem_line_model (input wire logic CLK, output logic [1:0] CTS_N, output logic [1:0] DCD_N);
    timeunit 1ns;
    timeprecision 1ns;
    initial {CTS_N, DCD_N} = 4'hF;
    // Pins move just after an edge; low means ready or carrier present
    task automatic drive(input logic [3:0] v);
        @(posedge CLK) {CTS_N, DCD_N} <= v;
    endtask
endmodule

//--- tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RST = 1, CE = 1;
    logic [1:0] rd = 0, en = 0, CTS_N, DCD_N, irq;
    logic [15:0] st;
    int n_errors = 0, num_checks = 0, cyc = 0;
    always #25 CLK = ~CLK;
    modem_line_model u_modem_line_model (.CLK, .CTS_N, .DCD_N);
    modem_status_inputs u_modem_status_inputs (.CLK, .RST, .CE, .CTS_N, .DCD_N, .STATUS_READ(rd),
        .MODEM_IRQ_ENABLE(en), .MODEM_STATUS_REGISTER(st), .MODEM_IRQ(irq));
    // Wait for the sync pipeline, then compare both channels
    task automatic chk(input logic [15:0] s, input logic [1:0] i);
        repeat (6) @(posedge CLK);
        #5 num_checks++;
        if (st !== s || irq !== i) n_errors++;
        if (st !== s || irq !== i) $display("CHECK FAILED %0t st %h irq %b", $time, st, irq);
    endtask
    // One-cycle read strobe per selected channel
    task automatic rdp(input logic [1:0] m);
        @(posedge CLK) rd <= m;
        @(posedge CLK) rd <= 2'h0;
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (6) @(posedge CLK);
        RST <= 0;
        chk(16'h0000, 2'h0);
        @(posedge CLK) en <= 2'h1;
        u_modem_line_model.drive(4'hB);
        chk(16'h0011, 2'h1);
        u_modem_line_model.drive(4'h9);
        chk(16'h8811, 2'h1);
        rdp(2'h1);
        chk(16'h8810, 2'h0);
        @(posedge CLK) en <= 2'h3;
        chk(16'h8810, 2'h2);
        @(posedge CLK) en <= 2'h0;
        chk(16'h8810, 2'h0);
        rdp(2'h2);
        u_modem_line_model.drive(4'hF);
        chk(16'h0801, 2'h0);
        rdp(2'h3);
        chk(16'h0000, 2'h0);
        // One-cycle glitch on a carrier pin must be filtered out
        u_modem_line_model.drive(4'hE);
        u_modem_line_model.drive(4'hF);
        chk(16'h0000, 2'h0);
        // Enable low freezes the pipeline; release lets the change through
        @(posedge CLK) CE <= 1'b0;
        u_modem_line_model.drive(4'hE);
        chk(16'h0000, 2'h0);
        @(posedge CLK) CE <= 1'b1;
        chk(16'h0088, 2'h0);
        u_modem_line_model.drive(4'hF);
        chk(16'h0008, 2'h0);
        // Mid-run reset clears a standing flag
        @(posedge CLK) RST <= 1'b1;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        chk(16'h0000, 2'h0);
        end_sim();
    end
endmodule
